// file: desc_defines.vh
/*
  constants for the debug exception and debug state controller:
  register offsets, status field positions, entry codes and link offsets.
  assumes inclusion by bare name from the controller source.
*/
`ifndef DESC_DEFINES_VH
`define DESC_DEFINES_VH

// register byte offsets on the avalon bus (word aligned)
`define DESC_OFS_STATUS 8'h00
`define DESC_OFS_IFS 8'h04
`define DESC_OFS_DFS 8'h08
`define DESC_OFS_FAR 8'h0C
`define DESC_OFS_WATCHPOINT_FAULT_ADDRESS 8'h10
`define DESC_OFS_PC 8'h14
`define DESC_OFS_CMD 8'h18
`define DESC_OFS_ALR 8'h1C

// debug_status_control field positions
`define DESC_ST_HALTED 0
`define DESC_ST_RESTARTED 1
`define DESC_ST_MOE_LO 2
`define DESC_ST_MOE_HI 5
`define DESC_ST_EXEC_EN 13
`define DESC_ST_MODE_LO 14
`define DESC_ST_MODE_HI 15

// writable status bits: exec enable and mode field
`define DESC_ST_WMASK 32'h0000E000
`define DESC_ST_RESET 32'h00000002

// debug modes in bits 15:14
`define DESC_MODE_NONE 2'h0
`define DESC_MODE_MON 2'h2

// method-of-entry codes
`define DESC_MOE_HALT 4'h0
`define DESC_MOE_BRK 4'h1
`define DESC_MOE_WPT 4'h2
`define DESC_MOE_BREAKPOINT_INSTRUCTION 4'h3
`define DESC_MOE_EXT 4'h4
`define DESC_MOE_VEC 4'h5

// fault status values written on debug exception
`define DESC_FS_DEBUG 32'h00000002

// instruction set states
`define DESC_ISA_32 2'h0
`define DESC_ISA_16 2'h1
`define DESC_ISA_BC 2'h2

// link and pc offsets
`define DESC_OFF_4 32'h00000004
`define DESC_OFF_8 32'h00000008

// command register bits
`define DESC_CMD_HALT 0
`define DESC_CMD_RESTART 1

// bytecode switch clears register bits from this position upward
`define DESC_BC_CLR_LO 9

// value left in undefined-content registers
`define DESC_UNDEF_VAL 32'hDEADBEEF

`endif

// file: desc_ctrl.v
/*
  debug exception and debug state controller for a processor core.
  decides per debug event between ignoring, a monitor-mode exception that
  reuses the abort entry sequences, and halting debug state; keeps the
  fault registers, a frozen program counter and the restart handshake.
  assumes the pipeline reports one committed event per cycle with its
  return address, and that event matching happens elsewhere.
*/
// Notes on behaviour
// RULE1: monitor mode turns software events into exceptions
// RULE2: monitor ignores abort-vector catch events
// RULE3: monitor ignores privileged unlinked context breakpoints
// RULE4: watchpoint exception sets entry code, data abort
// RULE5: watchpoint link is restart plus eight
// RULE6: breakpoint/breakpoint_instruction/vector exception uses prefetch abort
// RULE7: link plus four, watchpoint/data plus eight
// RULE8: watchpoints imprecise, return address may lag
// RULE9: entry sets halted, acknowledge, entry code
// RULE10: entry updates fault registers, watch address undefined; code keeps fault registers, captures watch address
// RULE11: halted core flushes, fetches nothing, keeps mode
// RULE12: dma engine keeps running in debug
// RULE13: debug state ignores events and halt requests
// RULE14: forced execution only with exec enable bit
// RULE15: restart clears restarted flag, exit sets it
// RULE16: pc frozen except direct writes
// RULE17: pc read gives offset by instruction state
// RULE18: restart resumes at written pc address
// RULE19: pc reads undefined after pc writes
// RULE20: switch to bytecode clears bits fifteen to nine
// RULE21: interrupts ignored in debug, masks untouched
// RULE22: external request code 0100, tap halt 0000
// RULE23: mode field selects none, monitor, halting
// RULE24: distinct entry code per event type
`include "desc_defines.vh"

module desc_ctrl #(
  parameter AW = 8
) (
  input wire core_clk_i, // core clock, 40 mhz
  input wire rst_n_i, // asynchronous reset, active low
  input wire clk_en_i, // freezes all state while low
  input wire [AW-1:0] avs_address_i, // avalon byte address
  input wire avs_read_i, // avalon read
  input wire avs_write_i, // avalon write
  input wire [31:0] avs_writedata_i, // avalon write data
  input wire [3:0] avs_byteenable_i, // avalon byte enables
  output reg [31:0] avs_readdata_o, // avalon read data
  output reg avs_waitrequest_o, // avalon wait
  output reg [1:0] avs_response_o, // 00 okay, 10 slave error
  input wire debug_enable_input_i, // debug enable
  input wire external_halt_request_i, // external halt request level
  input wire evt_valid_i, // a debug event committed this cycle
  input wire [2:0] evt_kind_i, // 0 brk 1 wpt 2 breakpoint_instruction 3 vec
  input wire evt_vec_abort_i, // vector catch on an abort vector
  input wire evt_ctx_unlinked_i, // breakpoint is unlinked context match
  input wire priv_mode_i, // core runs privileged
  input wire [1:0] isa_state_i, // 0 32-bit, 1 16-bit, 2 bytecode
  input wire [31:0] ret_addr_i, // return address of the event
  input wire [31:0] wpt_addr_i, // address that hit the watchpoint
  input wire [31:0] forced_pc_i, // pc written by a forced instruction
  input wire forced_pc_we_i, // forced instruction writes pc
  input wire forced_psr_we_i, // forced instruction writes status
  input wire to_bytecode_i, // forced switch 32-bit to bytecode
  input wire [15:0] reg_low_i, // register low half before switch
  input wire core_exited_i, // pipeline has left debug state
  input wire irq_i, // interrupt request from outside
  output reg prefetch_abort_o, // take prefetch abort entry, pulse
  output reg data_abort_o, // take data abort entry, pulse
  output reg [31:0] abort_link_register_o, // link value for abort entry
  output reg debug_acknowledge_o, // core in debug state
  output reg halt_pipe_o, // flush pipeline, fetch nothing
  output reg exec_allowed_o, // forced execution permitted
  output reg restart_o, // restart strobe to pipeline
  output reg [31:0] restart_pc_o, // resume address
  output reg [15:0] reg_low_o, // register low half after switch
  output reg irq_take_o // interrupt passed to core
);

  // run, halted, and waiting for the pipeline to leave after a restart
  localparam S_RUN = 2'h0;
  localparam S_HALT = 2'h1;
  localparam S_EXIT = 2'h2;

  localparam K_BRK = 3'h0;
  localparam K_WPT = 3'h1;
  localparam K_BREAKPOINT_INSTRUCTION = 3'h2;

  reg [1:0] state_ff, nxt_state;
  reg [31:0] status_ff, nxt_status;
  reg [31:0] ifs_ff, nxt_ifs;
  reg [31:0] dfs_ff, nxt_dfs;
  reg [31:0] far_ff, nxt_far;
  reg [31:0] watchpoint_fault_address_ff, nxt_watchpoint_fault_address;
  reg [31:0] pc_ff, nxt_pc;
  reg pc_written_ff, nxt_pc_written;
  reg pc_undef_ff, nxt_pc_undef;
  reg tap_halt_ff, nxt_tap_halt;
  reg tap_restart_ff, nxt_tap_restart;
  reg [31:0] rdata;
  reg bus_err;

  wire [1:0] mode = status_ff[`DESC_ST_MODE_HI:`DESC_ST_MODE_LO];
  wire enabled = debug_enable_input_i && (mode != `DESC_MODE_NONE); // [RULE23]
  wire monitor = enabled && (mode == `DESC_MODE_MON); // [RULE23]
  wire halting = enabled && !monitor; // [RULE23]
  wire in_debug = (state_ff != S_RUN);
  wire bus_req = avs_read_i || avs_write_i;
  wire wr_acc = avs_write_i && !avs_waitrequest_o;

  // monitor filtering: abort vector catches and privileged context hits drop out
  // the filters apply in monitor mode only; halting mode still stops on them
  wire mon_ignore = (evt_kind_i == 3'h3 && evt_vec_abort_i) || // [RULE2]
                    (evt_kind_i == K_BRK && evt_ctx_unlinked_i && priv_mode_i); // [RULE3]
  wire sw_evt = evt_valid_i && !in_debug; // [RULE13]

  // entry code per event kind, each one distinct
  reg [3:0] evt_moe;
  always @*
  begin
    case (evt_kind_i)
      K_BRK: evt_moe = `DESC_MOE_BRK; // [RULE24]
      K_WPT: evt_moe = `DESC_MOE_WPT; // [RULE24]
      K_BREAKPOINT_INSTRUCTION: evt_moe = `DESC_MOE_BREAKPOINT_INSTRUCTION; // [RULE24]
      default: evt_moe = `DESC_MOE_VEC; // [RULE24]
    endcase
  end

  // pc read offset by instruction set state
  // bytecode state reads the return address itself, without an offset
  reg [31:0] pc_view;
  always @*
  begin
    case (isa_state_i)
      `DESC_ISA_32: pc_view = ret_addr_i + `DESC_OFF_8; // [RULE17]
      `DESC_ISA_16: pc_view = ret_addr_i + `DESC_OFF_4; // [RULE17]
      default: pc_view = ret_addr_i; // [RULE17]
    endcase
  end

  // read mux; unmapped offsets answer with a slave error
  // the command offset is write-only and always reads as zero
  always @*
  begin
    rdata = 32'h00000000;
    bus_err = 1'b0;
    case (avs_address_i[7:0])
      `DESC_OFS_STATUS: rdata = status_ff;
      `DESC_OFS_IFS: rdata = ifs_ff;
      `DESC_OFS_DFS: rdata = dfs_ff;
      `DESC_OFS_FAR: rdata = far_ff;
      `DESC_OFS_WATCHPOINT_FAULT_ADDRESS: rdata = watchpoint_fault_address_ff;
      `DESC_OFS_PC: rdata = pc_undef_ff ? `DESC_UNDEF_VAL : pc_ff; // [RULE19]
      `DESC_OFS_CMD: rdata = 32'h00000000;
      `DESC_OFS_ALR: rdata = abort_link_register_o;
      default: bus_err = 1'b1;
    endcase
  end

  // control: event handling, entry, restart handshake
  always @*
  begin
    nxt_state = state_ff;
    nxt_status = status_ff;
    nxt_ifs = ifs_ff;
    nxt_dfs = dfs_ff;
    nxt_far = far_ff;
    nxt_watchpoint_fault_address = watchpoint_fault_address_ff;
    nxt_pc = pc_ff;
    nxt_pc_written = pc_written_ff;
    nxt_pc_undef = pc_undef_ff;
    nxt_tap_halt = 1'b0;
    nxt_tap_restart = 1'b0;
    // software writes: mode and exec-enable bits only
    if (wr_acc && avs_address_i[7:0] == `DESC_OFS_STATUS && avs_byteenable_i[1])
      nxt_status = (status_ff & ~`DESC_ST_WMASK) | (avs_writedata_i & `DESC_ST_WMASK);
    // command bits are one-cycle pulses; a halt written in debug state is lost
    if (wr_acc && avs_address_i[7:0] == `DESC_OFS_CMD && avs_byteenable_i[0])
    begin
      nxt_tap_halt = avs_writedata_i[`DESC_CMD_HALT];
      nxt_tap_restart = avs_writedata_i[`DESC_CMD_RESTART];
    end
    case (state_ff)
      S_RUN:
      begin
        if (debug_enable_input_i && (tap_halt_ff || external_halt_request_i ||
            (sw_evt && halting)))
        begin
          // halting entry: any mode when a request is pending
          nxt_state = S_HALT;
          nxt_status[`DESC_ST_HALTED] = 1'b1; // [RULE9]
          if (sw_evt && halting)
            nxt_status[`DESC_ST_MOE_HI:`DESC_ST_MOE_LO] = evt_moe; // [RULE9]
          else if (external_halt_request_i)
            nxt_status[`DESC_ST_MOE_HI:`DESC_ST_MOE_LO] = `DESC_MOE_EXT; // [RULE22]
          else
            nxt_status[`DESC_ST_MOE_HI:`DESC_ST_MOE_LO] = `DESC_MOE_HALT; // [RULE22]
          // fault registers left alone on entry, watch address captured
          if (sw_evt && halting && evt_kind_i == K_WPT)
            nxt_watchpoint_fault_address = wpt_addr_i; // [RULE10]
          nxt_pc = pc_view; // [RULE17]
          nxt_pc_written = 1'b0;
          nxt_pc_undef = 1'b0;
        end
        else if (sw_evt && monitor && !mon_ignore) // [RULE1]
        begin
          nxt_status[`DESC_ST_MOE_HI:`DESC_ST_MOE_LO] = evt_moe; // [RULE4] [RULE6]
          if (evt_kind_i == K_WPT)
          begin
            nxt_dfs = `DESC_FS_DEBUG; // [RULE4]
            nxt_far = `DESC_UNDEF_VAL; // [RULE5]
            nxt_watchpoint_fault_address = wpt_addr_i; // [RULE5]
          end
          else
            nxt_ifs = `DESC_FS_DEBUG; // [RULE6]
        end
      end
      S_HALT:
      begin
        // requests and events are simply dropped here
        if (forced_pc_we_i && status_ff[`DESC_ST_EXEC_EN])
        begin
          nxt_pc = forced_pc_i; // [RULE16] [RULE18]
          nxt_pc_written = 1'b1;
          nxt_pc_undef = 1'b1; // [RULE19]
        end
        // a status write also spoils later pc reads; restart keeps the written pc
        if (forced_psr_we_i && status_ff[`DESC_ST_EXEC_EN])
          nxt_pc_undef = 1'b1; // [RULE19]
        if (tap_restart_ff)
        begin
          nxt_status[`DESC_ST_RESTARTED] = 1'b0; // [RULE15]
          nxt_state = S_EXIT;
        end
      end
      S_EXIT:
      begin
        // the exit level stays high from an earlier exit until the pipeline is halted
        // again, which happens long before a restart can reach this state
        if (core_exited_i)
        begin
          nxt_status[`DESC_ST_RESTARTED] = 1'b1; // [RULE15]
          nxt_status[`DESC_ST_HALTED] = 1'b0; // [RULE15]
          nxt_state = S_RUN;
        end
      end
      default: nxt_state = S_RUN;
    endcase
  end

  // bytecode switch clears the upper register bits, one lane per bit, so the
  // cleared range follows the boundary constant instead of a hand-made mask
  wire bc_switch = (state_ff == S_HALT) && to_bytecode_i && status_ff[`DESC_ST_EXEC_EN];
  wire [15:0] low_kept;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_low_lane
      if (gi >= `DESC_BC_CLR_LO)
      begin : g_clr
        assign low_kept[gi] = reg_low_i[gi] && !bc_switch;
      end
      else
      begin : g_keep
        assign low_kept[gi] = reg_low_i[gi];
      end
    end
  endgenerate

  // state registers; reset also drops the core out of debug state
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= S_RUN;
      status_ff <= `DESC_ST_RESET;
      ifs_ff <= 32'h00000000;
      dfs_ff <= 32'h00000000;
      far_ff <= 32'h00000000;
      watchpoint_fault_address_ff <= 32'h00000000;
      pc_ff <= 32'h00000000;
      pc_written_ff <= 1'b0;
      pc_undef_ff <= 1'b0;
      tap_halt_ff <= 1'b0;
      tap_restart_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_ff <= nxt_state;
      status_ff <= nxt_status;
      ifs_ff <= nxt_ifs;
      dfs_ff <= nxt_dfs;
      far_ff <= nxt_far;
      watchpoint_fault_address_ff <= nxt_watchpoint_fault_address;
      pc_ff <= nxt_pc;
      pc_written_ff <= nxt_pc_written;
      pc_undef_ff <= nxt_pc_undef;
      tap_halt_ff <= nxt_tap_halt;
      tap_restart_ff <= nxt_tap_restart;
    end
  end

  // core-facing outputs, all registered
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prefetch_abort_o <= 1'b0;
      data_abort_o <= 1'b0;
      abort_link_register_o <= 32'h00000000;
      debug_acknowledge_o <= 1'b0;
      halt_pipe_o <= 1'b0;
      exec_allowed_o <= 1'b0;
      restart_o <= 1'b0;
      restart_pc_o <= 32'h00000000;
      reg_low_o <= 16'h0000;
      irq_take_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      prefetch_abort_o <= 1'b0;
      data_abort_o <= 1'b0;
      restart_o <= 1'b0;
      if (state_ff == S_RUN && !(debug_enable_input_i && (tap_halt_ff ||
          external_halt_request_i || (sw_evt && halting))) &&
          sw_evt && monitor && !mon_ignore)
      begin
        // return address may trail the watchpoint hit by several instructions
        if (evt_kind_i == K_WPT)
        begin
          data_abort_o <= 1'b1; // [RULE4] [RULE8]
          abort_link_register_o <= ret_addr_i + `DESC_OFF_8; // [RULE5] [RULE7]
        end
        else
        begin
          prefetch_abort_o <= 1'b1; // [RULE6]
          abort_link_register_o <= ret_addr_i + `DESC_OFF_4; // [RULE7]
        end
      end
      debug_acknowledge_o <= nxt_status[`DESC_ST_HALTED]; // [RULE9] [RULE15]
      // only the pipeline stops here; the dma engine has no stop and runs on
      halt_pipe_o <= (nxt_state != S_RUN); // [RULE11] [RULE12]
      exec_allowed_o <= (nxt_state == S_HALT) && nxt_status[`DESC_ST_EXEC_EN]; // [RULE14]
      if (state_ff == S_HALT && tap_restart_ff)
      begin
        restart_o <= 1'b1; // [RULE18]
        restart_pc_o <= pc_written_ff ? pc_ff : `DESC_UNDEF_VAL; // [RULE18]
      end
      reg_low_o <= low_kept; // [RULE20]
      // an interrupt held through debug state is passed on once the core runs
      irq_take_o <= irq_i && (nxt_state == S_RUN); // [RULE21]
    end
  end

  // avalon slave: one wait cycle, then the answer; waitrequest idles high so every
  // request sees the same single wait state, at the cost of a cycle per access
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      avs_response_o <= 2'h0;
    end
    else if (clk_en_i)
    begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
      if (bus_req && avs_waitrequest_o)
      begin
        avs_readdata_o <= avs_read_i ? rdata : 32'h00000000;
        avs_response_o <= bus_err ? 2'h2 : 2'h0;
      end
    end
  end

endmodule

// file: desc_ctrl_props.sv
/*
  concurrent checks for the debug exception and debug state controller.
  assumes binding onto desc_ctrl, core clock with asynchronous active-low reset.
*/
module desc_ctrl_props (
  input wire core_clk_i, // clock
  input wire rst_n_i, // reset, active low
  input wire debug_enable_input_i, // debug enable
  input wire evt_valid_i, // event strobe
  input wire [2:0] evt_kind_i, // event kind
  input wire evt_vec_abort_i, // abort vector catch
  input wire evt_ctx_unlinked_i, // unlinked context match
  input wire priv_mode_i, // privileged
  input wire [31:0] ret_addr_i, // return address
  input wire to_bytecode_i, // bytecode switch
  input wire core_exited_i, // pipeline left debug
  input wire prefetch_abort_o, // prefetch abort pulse
  input wire data_abort_o, // data abort pulse
  input wire [31:0] abort_link_register_o, // abort link
  input wire debug_acknowledge_o, // in debug
  input wire restart_o, // restart strobe
  input wire [15:0] reg_low_o, // low half after switch
  input wire irq_take_o // interrupt passed on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // abort entries only follow a matching event, one cycle later
  property p_pabt_cause;
    prefetch_abort_o |-> $past(evt_valid_i) && $past(evt_kind_i) != 3'h1;
  endproperty
  a_pabt_cause: assert property (p_pabt_cause) else $error("stray prefetch abort");
  property p_dabt_cause;
    data_abort_o |-> $past(evt_valid_i && evt_kind_i == 3'h1 && debug_enable_input_i);
  endproperty
  a_dabt_cause: assert property (p_dabt_cause) else $error("stray data abort");
  property p_link_pabt;
    prefetch_abort_o |-> abort_link_register_o == $past(ret_addr_i) + 32'h4;
  endproperty
  a_link_pabt: assert property (p_link_pabt) else $error("bad prefetch link");
  property p_link_dabt;
    data_abort_o |-> abort_link_register_o == $past(ret_addr_i) + 32'h8;
  endproperty
  a_link_dabt: assert property (p_link_dabt) else $error("bad data link");
  // events that must be dropped
  property p_vec_ign;
    evt_valid_i && evt_kind_i == 3'h3 && evt_vec_abort_i |=> !prefetch_abort_o && !data_abort_o;
  endproperty
  a_vec_ign: assert property (p_vec_ign) else $error("abort vector catch taken");
  property p_ctx_ign;
    evt_valid_i && evt_kind_i == 3'h0 && evt_ctx_unlinked_i && priv_mode_i |=> !prefetch_abort_o;
  endproperty
  a_ctx_ign: assert property (p_ctx_ign) else $error("context event taken");
  property p_dbg_ign;
    debug_acknowledge_o && evt_valid_i |=> !prefetch_abort_o && !data_abort_o;
  endproperty
  a_dbg_ign: assert property (p_dbg_ign) else $error("event taken in debug");
  property p_irq_blk;
    debug_acknowledge_o && $past(debug_acknowledge_o) |-> !irq_take_o;
  endproperty
  a_irq_blk: assert property (p_irq_blk) else $error("interrupt in debug");
  // exit handshake: single strobe, ack drops soon after the pipeline leaves
  property p_exit;
    $rose(core_exited_i) && debug_acknowledge_o |-> ##[1:3] !debug_acknowledge_o;
  endproperty
  a_exit: assert property (p_exit) else $error("ack held after exit");
  property p_rs_once;
    restart_o |-> debug_acknowledge_o ##1 !restart_o;
  endproperty
  a_rs_once: assert property (p_rs_once) else $error("bad restart strobe");
  property p_bc;
    debug_acknowledge_o && to_bytecode_i |=> reg_low_o[15:9] == 7'h0;
  endproperty
  a_bc: assert property (p_bc) else $error("bits not cleared on switch");
  c_pabt: cover property (prefetch_abort_o);
  c_dabt: cover property (data_abort_o);
  c_rs: cover property (restart_o);
endmodule

bind desc_ctrl desc_ctrl_props i_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .debug_enable_input_i(debug_enable_input_i),
  .evt_valid_i(evt_valid_i), .evt_kind_i(evt_kind_i), .evt_vec_abort_i(evt_vec_abort_i),
  .evt_ctx_unlinked_i(evt_ctx_unlinked_i), .priv_mode_i(priv_mode_i), .ret_addr_i(ret_addr_i),
  .to_bytecode_i(to_bytecode_i), .core_exited_i(core_exited_i),
  .prefetch_abort_o(prefetch_abort_o), .data_abort_o(data_abort_o),
  .abort_link_register_o(abort_link_register_o), .debug_acknowledge_o(debug_acknowledge_o),
  .restart_o(restart_o), .reg_low_o(reg_low_o), .irq_take_o(irq_take_o));

// file: desc_core_model.sv
/*
  pipeline-side partner: stops when halted, leaves debug a set delay after restart.
  assumes the controller's halt and restart outputs on the core clock.
*/
module desc_core_model (
  input wire core_clk_i, // core clock
  input wire rst_n_i, // reset, active low
  input wire halt_pipe_i, // flush and stop fetch
  input wire restart_i, // restart strobe
  input wire [3:0] exit_delay_i, // exit follows the restart strobe by this count plus one cycle
  output logic core_exited_o // pipeline has left debug
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff;
  logic run_ff;
  logic halt_d_ff;
  // exit level held until the next halt; a long delay keeps ack up longer
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= 4'h0;
      run_ff <= 1'b0;
      halt_d_ff <= 1'b0;
      core_exited_o <= 1'b0;
    end
    else
    begin
      halt_d_ff <= halt_pipe_i;
      if (halt_pipe_i && !halt_d_ff)
        core_exited_o <= 1'b0;
      if (restart_i)
      begin
        run_ff <= 1'b1;
        cnt_ff <= exit_delay_i;
      end
      else if (run_ff && cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
      else if (run_ff)
      begin
        run_ff <= 1'b0;
        core_exited_o <= 1'b1;
      end
    end
  end
endmodule

// file: tb_debug_exception_state_ctrl.sv
/*
  self-checking bench: avalon register tasks, event pulses and debug entry/exit.
  assumes desc_ctrl with the checker bound and the pipeline-side model attached.
*/
`include "desc_defines.vh"
module tb_debug_exception_state_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, avs_read_i = 1'b0;
  logic avs_write_i = 1'b0, debug_enable_input_i = 1'b0, external_halt_request_i = 1'b0;
  logic evt_valid_i = 1'b0, evt_vec_abort_i = 1'b0, evt_ctx_unlinked_i = 1'b0;
  logic priv_mode_i = 1'b0, forced_pc_we_i = 1'b0, forced_psr_we_i = 1'b0;
  logic to_bytecode_i = 1'b0, irq_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, ret_addr_i = 32'h0, forced_pc_i = 32'h0;
  logic [31:0] wpt_addr_i = 32'h00002468, rdata, lnk, rs_pc;
  logic [3:0] avs_byteenable_i = 4'hF, exit_delay = 4'h1;
  logic [2:0] evt_kind_i = 3'h0;
  logic [1:0] isa_state_i = 2'h0, resp;
  logic [15:0] reg_low_i = 16'h0;
  logic [3:0] moe_tab [4] = '{`DESC_MOE_BRK, `DESC_MOE_WPT, `DESC_MOE_BREAKPOINT_INSTRUCTION, `DESC_MOE_VEC};
  wire core_exited_i, avs_waitrequest_o, prefetch_abort_o, data_abort_o, debug_acknowledge_o;
  wire halt_pipe_o, exec_allowed_o, restart_o, irq_take_o;
  wire [31:0] avs_readdata_o, abort_link_register_o, restart_pc_o;
  wire [1:0] avs_response_o;
  wire [15:0] reg_low_o;
  int failures = 0, cmp_count = 0, n_pa = 0, n_da = 0;
  desc_ctrl i_dut (.*);
  desc_core_model i_core (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .halt_pipe_i(halt_pipe_o), .restart_i(restart_o), .exit_delay_i(exit_delay),
    .core_exited_o(core_exited_i));
  // 40 mhz core clock
  initial
  begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // pulse outputs last one cycle, so they are caught here rather than polled
  always @(posedge core_clk_i)
  begin
    n_pa += (prefetch_abort_o === 1'b1);
    n_da += (data_abort_o === 1'b1);
    if (prefetch_abort_o === 1'b1 || data_abort_o === 1'b1)
      lnk = abort_link_register_o;
    if (restart_o === 1'b1)
      rs_pc = restart_pc_o;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rdata = avs_readdata_o;
    resp = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic ev(input logic [2:0] k, input logic va, input logic cx, input logic [31:0] ra);
    @(posedge core_clk_i);
    evt_valid_i <= 1'b1;
    evt_kind_i <= k;
    evt_vec_abort_i <= va;
    evt_ctx_unlinked_i <= cx;
    priv_mode_i <= cx;
    ret_addr_i <= ra;
    @(posedge core_clk_i);
    evt_valid_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (debug_acknowledge_o !== lvl && n < 200)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      tally_and_finish();
    end
  endtask
  // pulse a one-cycle strobe from forced execution
  task automatic strobe(input int which);
    @(posedge core_clk_i);
    if (which == 0)
      forced_pc_we_i <= 1'b1;
    else
      to_bytecode_i <= 1'b1;
    @(posedge core_clk_i);
    forced_pc_we_i <= 1'b0;
    to_bytecode_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rdc(`DESC_OFS_STATUS, `DESC_ST_RESET);
    bus(1'b0, 8'h20, 32'h0);
    chk({30'h0, resp}, 32'h2);
    bus(1'b1, `DESC_OFS_STATUS, 32'h00008000);
    ev(3'h0, 1'b0, 1'b0, 32'h100);
    chk(32'(n_pa + n_da), 32'h0);
    $display("test reset and disabled done");
    debug_enable_input_i <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ev(3'(k), 1'b0, 1'b0, 32'h1000 + 32'(k * 16));
      chk(32'(n_pa + n_da), 32'(k + 1));
      chk(lnk, 32'h1000 + 32'(k * 16) + ((k == 1) ? 32'h8 : 32'h4));
      rdc(`DESC_OFS_STATUS, 32'h00008002 | {26'h0, moe_tab[k], 2'h0});
      rdc((k == 1) ? `DESC_OFS_DFS : `DESC_OFS_IFS, `DESC_FS_DEBUG);
    end
    rdc(`DESC_OFS_WATCHPOINT_FAULT_ADDRESS, 32'h00002468);
    rdc(`DESC_OFS_FAR, `DESC_UNDEF_VAL);
    ev(3'h3, 1'b1, 1'b0, 32'h200);
    ev(3'h0, 1'b0, 1'b1, 32'h300);
    chk(32'(n_pa + n_da), 32'h4);
    $display("test monitor done");
    bus(1'b1, `DESC_OFS_STATUS, 32'h00006000);
    ret_addr_i <= 32'h3000;
    external_halt_request_i <= 1'b1;
    wait_ack(1'b1);
    external_halt_request_i <= 1'b0;
    rdc(`DESC_OFS_STATUS, 32'h00006013);
    chk({31'h0, exec_allowed_o}, 32'h1);
    chk({31'h0, halt_pipe_o}, 32'h1);
    rdc(`DESC_OFS_PC, 32'h3008);
    ev(3'h0, 1'b0, 1'b0, 32'h400);
    rdc(`DESC_OFS_STATUS, 32'h00006013);
    rdc(`DESC_OFS_PC, 32'h3008);
    irq_i <= 1'b1;
    reg_low_i <= 16'hFFFF;
    strobe(1);
    chk({16'h0, reg_low_o}, 32'h01FF);
    chk({31'h0, irq_take_o}, 32'h0);
    irq_i <= 1'b0;
    forced_pc_i <= 32'h4000;
    strobe(0);
    bus(1'b1, `DESC_OFS_CMD, 32'h2);
    wait_ack(1'b0);
    chk(rs_pc, 32'h4000);
    rdc(`DESC_OFS_STATUS, 32'h00006012);
    chk({31'h0, halt_pipe_o}, 32'h0);
    irq_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk({31'h0, irq_take_o}, 32'h1);
    irq_i <= 1'b0;
    $display("test halting entry and restart done");
    isa_state_i <= 2'h1;
    ret_addr_i <= 32'h5000;
    exit_delay <= 4'h9;
    bus(1'b1, `DESC_OFS_CMD, 32'h1);
    wait_ack(1'b1);
    rdc(`DESC_OFS_STATUS, 32'h00006003);
    rdc(`DESC_OFS_PC, 32'h5004);
    bus(1'b1, `DESC_OFS_CMD, 32'h2);
    wait_ack(1'b0);
    rdc(`DESC_OFS_STATUS, 32'h00006002);
    chk(rs_pc, `DESC_UNDEF_VAL);
    wpt_addr_i <= 32'h00001357;
    ev(3'h1, 1'b0, 1'b0, 32'h6000);
    wait_ack(1'b1);
    rdc(`DESC_OFS_STATUS, 32'h0000600B);
    rdc(`DESC_OFS_WATCHPOINT_FAULT_ADDRESS, 32'h00001357);
    rdc(`DESC_OFS_DFS, `DESC_FS_DEBUG);
    rdc(`DESC_OFS_PC, 32'h6004);
    chk(32'(n_pa + n_da), 32'h4);
    bus(1'b1, `DESC_OFS_CMD, 32'h2);
    wait_ack(1'b0);
    $display("test tap halt and slow exit done");
    tally_and_finish();
  end
endmodule
